// ### rtl/gpib_pkg.sv
// gpib_pkg: shared constants and carrier types for the instrument bus port
// assumes a single 100 MHz clock domain
package gpib_pkg;
   localparam int GPIB_DATA_W = 8;
   localparam int GPIB_ADDR_W = 5;
   localparam int GPIB_RSEL_W = 3;
   localparam int GPIB_FIFO_DEPTH = 4;
   // command byte layout: address in the low five bits, role in bits 5 and 6
   localparam int GPIB_LISTEN_BIT = 5;
   localparam int GPIB_TALK_BIT = 6;
   // register_select encodings
   localparam logic [2:0] GPIB_RS_DATA = 3'h0;
   localparam logic [2:0] GPIB_RS_STATUS = 3'h1;
   localparam logic [2:0] GPIB_RS_CTRL = 3'h2;
   localparam logic [2:0] GPIB_RS_ADDR = 3'h3;
   // control register bit positions
   localparam int GPIB_CTRL_SRQ = 0;
   localparam int GPIB_CTRL_EOI = 1;
   localparam logic [7:0] GPIB_BYTE_ZERO = 8'h00;
   localparam logic [1:0] GPIB_ROLE_IDLE = 2'h0;

   // bus lines in positive-true internal form
   typedef struct packed {
      logic atn;
      logic ifc;
      logic ren;
      logic eoi;
      logic dav;
      logic nrfd;
      logic ndac;
      logic [7:0] dio;
   } gpib_bus_s;

   // processor access strobes, active high internally
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] rsel;
      logic [7:0] wdata;
   } gpib_cpu_s;

   typedef enum logic [1:0] {GPIB_CMD, GPIB_DATA, GPIB_POLL} gpib_kind_e;
endpackage

// ### rtl/gpib_fifo.sv
// gpib_fifo: small flop-based fifo with valid/ready on both sides
// assumes writer and reader share clk
`timescale 1ns/1ps
module gpib_fifo
   #(parameter int WIDTH = 8,
     parameter int DEPTH = 4)
   (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
   );
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("fifo depth must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r, rp_r, wp_nxt, rp_nxt;
   logic push, pop;
   always_comb
   begin
      in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
      out_valid = wp_r != rp_r;
      out_data = mem_r[rp_r[AW-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wp_nxt = wp_r + (AW+1)'(push);
      rp_nxt = rp_r + (AW+1)'(pop);
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
   always_ff @(posedge clk)
   begin
      if (push)
         mem_r[wp_r[AW-1:0]] <= in_data;
   end
endmodule

// ### rtl/gpib_port.sv
// gpib_port: device-side instrument bus listener/talker with acceptor handshake
// assumes bus pins arrive unsynchronised and active low; processor strobes active low
`timescale 1ns/1ps
// Overview of operation
// - bus lines are asserted when low, negated when high
// - sixteen lines: eight data, three handshake, five management
// - bytes move whole in parallel, either direction, without common clock
// - handshake runs in hardware (here acceptor side only, DAV never driven); transceiver direction follows role and ATN
// - bus levels are inverted to positive-true inside
// - processor reset drives NDAC and NRFD low
// - bus address compared with switch value sampled once after reset
// - on match, DIO6 true DIO7 false means listener, else talker
// - ready listener negates NRFD while holding NDAC asserted
// - on DAV drop ready flag, capture byte, raise data-accepted
// - DAV negated makes device drop data-accepted
// - ready raised again only when another byte can be taken
// - chip select low with write low accepts processor write
// - register chosen by strobes plus three register_select inputs
// - IFC returns interface functions to idle
// - SRQ asserted while device needs attention
// - EOI marks last talker byte; EOI with ATN runs a poll
// - ATN decides command, data or poll meaning of a byte
// - REN enables remote mode
module gpib_port
   import gpib_pkg::*;
   #(parameter int FIFO_DEPTH = GPIB_FIFO_DEPTH)
   (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // bus pins, active low, open drain: oe low means driving low
   input wire logic [7:0] dio_n_in,
   output logic [7:0] dio_n_oe,
   input wire logic dav_n_in,
   output logic dav_n_oe,
   input wire logic nrfd_n_in,
   output logic nrfd_n_oe,
   input wire logic ndac_n_in,
   output logic ndac_n_oe,
   input wire logic atn_n_in,
   input wire logic ifc_n_in,
   input wire logic ren_n_in,
   input wire logic eoi_n_in,
   output logic eoi_n_oe,
   output logic srq_n_oe,
   output logic xcvr_transmit,
   // rear-panel address switch
   input wire logic [4:0] addr_switch,
   // processor port
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [2:0] register_select,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   // status
   output logic remote_mode,
   output logic listener_active,
   output logic talker_active
   );
   initial
   begin
      if (FIFO_DEPTH < 2)
         $error("fifo depth too small");
   end

   typedef enum logic [1:0] {GP_IDLE, GP_READY, GP_ACCEPT, GP_WAIT_RELEASE} gpib_hs_e;

   // two-flop synchronisers on every bus and processor input
   gpib_bus_s meta_r, bus_r, bus_nxt;
   gpib_cpu_s cmeta_r, cpu_r, cpu_nxt;
   logic [4:0] ameta_r, asyn_r;
   always_comb
   begin
      bus_nxt.atn = ~atn_n_in;
      bus_nxt.ifc = ~ifc_n_in;
      bus_nxt.ren = ~ren_n_in;
      bus_nxt.eoi = ~eoi_n_in;
      bus_nxt.dav = ~dav_n_in;
      bus_nxt.nrfd = ~nrfd_n_in;
      bus_nxt.ndac = ~ndac_n_in;
      bus_nxt.dio = ~dio_n_in;
      cpu_nxt.rd = ~cs_n & ~rd_n;
      cpu_nxt.wr = ~cs_n & ~wr_n;
      cpu_nxt.rsel = register_select;
      cpu_nxt.wdata = cpu_wdata;
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_r <= '0;
         bus_r <= '0;
         cmeta_r <= '0;
         cpu_r <= '0;
         ameta_r <= '0;
         asyn_r <= '0;
      end
      else
      begin
         meta_r <= bus_nxt;
         bus_r <= meta_r;
         cmeta_r <= cpu_nxt;
         cpu_r <= cmeta_r;
         ameta_r <= addr_switch;
         asyn_r <= ameta_r;
      end
   end

   // switch value caught once, a few cycles after reset release
   logic [1:0] boot_r, boot_nxt;
   logic [4:0] my_addr_r, my_addr_nxt;
   logic [1:0] role_r, role_nxt; // bit0 listener, bit1 talker
   gpib_hs_e hs_r, hs_nxt;
   logic [7:0] ctrl_r, ctrl_nxt, tx_r, tx_nxt, last_cmd_r, last_cmd_nxt;
   logic tx_full_r, tx_full_nxt, cmd_seen_r, cmd_seen_nxt, poll_r, poll_nxt;
   logic cpu_rd_q_r, cpu_wr_q_r;
   logic [7:0] rdata_nxt;
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic rd_edge, wr_edge;
   gpib_kind_e kind;

   function automatic gpib_kind_e classify(input logic atn, input logic eoi);
      if (atn && eoi)
         classify = GPIB_POLL;
      else if (atn)
         classify = GPIB_CMD;
      else
         classify = GPIB_DATA;
   endfunction

   gpib_fifo #(.WIDTH(GPIB_DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(bus_r.dio),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   always_comb
   begin
      rd_edge = cpu_r.rd & ~cpu_rd_q_r;
      wr_edge = cpu_r.wr & ~cpu_wr_q_r;
      kind = classify(bus_r.atn, bus_r.eoi);
      boot_nxt = (boot_r == 2'h3) ? boot_r : boot_r + 2'h1;
      my_addr_nxt = (boot_r == 2'h2) ? asyn_r : my_addr_r;
      role_nxt = role_r;
      hs_nxt = hs_r;
      ctrl_nxt = ctrl_r;
      tx_nxt = tx_r;
      tx_full_nxt = tx_full_r;
      last_cmd_nxt = last_cmd_r;
      cmd_seen_nxt = cmd_seen_r;
      poll_nxt = (kind == GPIB_POLL);
      fifo_in_valid = 1'b0;
      fifo_out_ready = 1'b0;
      // talker: one byte put out per processor write, handshake left to controller side
      // cleared ahead of the write decode so that a fresh load in the same cycle wins
      if (role_r[1] && tx_full_r && !bus_r.atn && !bus_r.nrfd && !bus_r.ndac)
         tx_full_nxt = 1'b0;
      // processor access
      if (wr_edge)
      begin
         case (cpu_r.rsel)
            GPIB_RS_DATA:
            begin
               tx_nxt = cpu_r.wdata;
               tx_full_nxt = 1'b1;
            end
            GPIB_RS_CTRL: ctrl_nxt = cpu_r.wdata;
            default: ctrl_nxt = ctrl_r;
         endcase
      end
      if (rd_edge && cpu_r.rsel == GPIB_RS_DATA)
         fifo_out_ready = 1'b1;
      if (rd_edge && cpu_r.rsel == GPIB_RS_STATUS)
         cmd_seen_nxt = 1'b0;
      // acceptor handshake
      case (hs_r)
         GP_IDLE:
            hs_nxt = GP_READY;
         GP_READY:
            if (bus_r.dav)
            begin
               if (kind != GPIB_DATA)
               begin
                  last_cmd_nxt = bus_r.dio;
                  cmd_seen_nxt = 1'b1;
                  if (bus_r.dio[4:0] == my_addr_r)
                     role_nxt = (bus_r.dio[GPIB_LISTEN_BIT] && !bus_r.dio[GPIB_TALK_BIT]) ? 2'h1 : 2'h2;
               end
               else if (role_r[0])
                  fifo_in_valid = 1'b1;
               hs_nxt = GP_ACCEPT;
            end
         GP_ACCEPT:
            hs_nxt = GP_WAIT_RELEASE;
         GP_WAIT_RELEASE:
            if (!bus_r.dav)
               hs_nxt = GP_IDLE;
         default: hs_nxt = GP_IDLE;
      endcase
      if (bus_r.ifc)
      begin
         role_nxt = GPIB_ROLE_IDLE;
         hs_nxt = GP_IDLE;
         tx_full_nxt = 1'b0;
      end
      rdata_nxt = GPIB_BYTE_ZERO;
      if (cpu_r.rd)
      begin
         case (cpu_r.rsel)
            // head caught at the strobe edge and held: after the pop the fifo shows the next byte
            GPIB_RS_DATA: rdata_nxt = rd_edge ? fifo_out_data : cpu_rdata;
            GPIB_RS_STATUS: rdata_nxt = {poll_r, bus_r.ren, cmd_seen_r, tx_full_r, fifo_out_valid, role_r, bus_r.atn};
            GPIB_RS_CTRL: rdata_nxt = ctrl_r;
            GPIB_RS_ADDR: rdata_nxt = {3'h0, my_addr_r};
            default: rdata_nxt = last_cmd_r;
         endcase
      end
   end

   logic ready_flag, accepted_flag;
   always_comb
   begin
      // ready only with room in the fifo: back-pressure reaches the bus
      ready_flag = (hs_r == GP_READY) && fifo_in_ready;
      accepted_flag = (hs_r == GP_WAIT_RELEASE);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         boot_r <= '0;
         my_addr_r <= '0;
         role_r <= GPIB_ROLE_IDLE;
         hs_r <= GP_IDLE;
         ctrl_r <= GPIB_BYTE_ZERO;
         tx_r <= GPIB_BYTE_ZERO;
         tx_full_r <= 1'b0;
         last_cmd_r <= GPIB_BYTE_ZERO;
         cmd_seen_r <= 1'b0;
         poll_r <= 1'b0;
         cpu_rd_q_r <= 1'b0;
         cpu_wr_q_r <= 1'b0;
         cpu_rdata <= GPIB_BYTE_ZERO;
         dio_n_oe <= 8'hff;
         dav_n_oe <= 1'b1;
         nrfd_n_oe <= 1'b0;
         ndac_n_oe <= 1'b0;
         eoi_n_oe <= 1'b1;
         srq_n_oe <= 1'b1;
         xcvr_transmit <= 1'b0;
         remote_mode <= 1'b0;
         listener_active <= 1'b0;
         talker_active <= 1'b0;
      end
      else
      begin
         boot_r <= boot_nxt;
         my_addr_r <= my_addr_nxt;
         role_r <= role_nxt;
         hs_r <= hs_nxt;
         ctrl_r <= ctrl_nxt;
         tx_r <= tx_nxt;
         tx_full_r <= tx_full_nxt;
         last_cmd_r <= last_cmd_nxt;
         cmd_seen_r <= cmd_seen_nxt;
         poll_r <= poll_nxt;
         cpu_rd_q_r <= cpu_r.rd;
         cpu_wr_q_r <= cpu_r.wr;
         cpu_rdata <= rdata_nxt;
         nrfd_n_oe <= ~(hs_nxt != GP_READY || !fifo_in_ready);
         ndac_n_oe <= ~(hs_nxt != GP_WAIT_RELEASE);
         xcvr_transmit <= role_nxt[1] && !bus_r.atn;
         dio_n_oe <= (role_nxt[1] && tx_full_nxt && !bus_r.atn) ? ~tx_nxt : 8'hff;
         eoi_n_oe <= ~(role_nxt[1] && ctrl_nxt[GPIB_CTRL_EOI]);
         srq_n_oe <= ~ctrl_nxt[GPIB_CTRL_SRQ];
         remote_mode <= bus_r.ren;
         listener_active <= role_nxt[0];
         talker_active <= role_nxt[1];
      end
   end

   property p_ifc_idle;
      @(posedge clk) disable iff (sys_rst) bus_r.ifc |=> (role_r == GPIB_ROLE_IDLE && hs_r == GP_IDLE);
   endproperty
   a_ifc_idle: assert property (p_ifc_idle) else $error("ifc did not idle interface");
   property p_accept_after_dav;
      @(posedge clk) disable iff (sys_rst) (hs_r == GP_READY && bus_r.dav && !bus_r.ifc) |=> accepted_flag == 1'b0 ##1 accepted_flag;
   endproperty
   a_accept_after_dav: assert property (p_accept_after_dav) else $error("data accepted not raised");
   property p_ndac_follows;
      @(posedge clk) disable iff (sys_rst) accepted_flag |-> !ndac_n_oe == 1'b0;
   endproperty
   a_ndac_follows: assert property (p_ndac_follows) else $error("ndac held during accept");
   property p_release;
      @(posedge clk) disable iff (sys_rst) (accepted_flag && !bus_r.dav) |=> !accepted_flag;
   endproperty
   a_release: assert property (p_release) else $error("accepted not dropped");
   property p_ready_needs_room;
      @(posedge clk) disable iff (sys_rst) nrfd_n_oe |-> $past(fifo_in_ready);
   endproperty
   a_ready_needs_room: assert property (p_ready_needs_room) else $error("ready without room");
   property p_not_ready_in_accept;
      @(posedge clk) disable iff (sys_rst) (hs_r == GP_WAIT_RELEASE) |-> nrfd_n_oe == 1'b0;
   endproperty
   a_not_ready_in_accept: assert property (p_not_ready_in_accept) else $error("nrfd released while accepting");
   property p_srq;
      @(posedge clk) disable iff (sys_rst) ctrl_r[GPIB_CTRL_SRQ] |-> !srq_n_oe;
   endproperty
   a_srq: assert property (p_srq) else $error("srq not driven");
   property p_ren;
      @(posedge clk) disable iff (sys_rst) $rose(bus_r.ren) |=> remote_mode;
   endproperty
   a_ren: assert property (p_ren) else $error("remote mode not set");
   property p_xcvr;
      @(posedge clk) disable iff (sys_rst) xcvr_transmit |-> talker_active;
   endproperty
   a_xcvr: assert property (p_xcvr) else $error("transmit while not talker");
endmodule

// ### testbench/gpib_ctrl_model.sv
// gpib_ctrl_model: behavioural bus controller that sources bytes over the three-wire handshake
// assumes the bench resolves the open-drain wires, released lines read high through pull-ups
`timescale 1ns/1ps
module gpib_ctrl_model
   (
   // clock
   input wire logic clk,
   // resolved wire levels
   input wire logic nrfd_n,
   input wire logic ndac_n,
   // lines pulled low by the controller
   output logic atn_n,
   output logic eoi_n,
   output logic dav_n,
   output logic [7:0] dio_n
   );
   initial
   begin
      atn_n = 1'h1;
      eoi_n = 1'h1;
      dav_n = 1'h1;
      dio_n = 8'hff;
   end
   task automatic set_mgmt(input logic atn, input logic eoi);
      begin
         @(posedge clk);
         #1;
         atn_n = ~atn;
         eoi_n = ~eoi;
      end
   endtask
   // one byte, prompt or with a gap; ok low means the device never answered
   task automatic send_byte(input logic atn, input logic [7:0] b, input int gap, output bit ok);
      int n;
      begin
         n = 0;
         @(posedge clk);
         #1;
         atn_n = ~atn;
         while (nrfd_n !== 1'h1 && n < 600)
         begin
            @(posedge clk);
            n++;
         end
         repeat (gap) @(posedge clk);
         #1;
         dio_n = ~b;
         @(posedge clk);
         #1;
         dav_n = 1'h0;
         while (ndac_n !== 1'h1 && n < 600)
         begin
            @(posedge clk);
            n++;
         end
         #1;
         dav_n = 1'h1;
         dio_n = 8'hff;
         atn_n = 1'h1;
         while (ndac_n !== 1'h0 && n < 600)
         begin
            @(posedge clk);
            n++;
         end
         ok = (n < 600);
      end
   endtask
endmodule

// ### testbench/tb.sv
// tb: self-checking bench for the instrument bus port
// assumes the controller model beside it and a 100 MHz clock
`timescale 1ns/1ps
module tb
   import gpib_pkg::*;
   ;
   logic clk, sys_rst, cs_n, rd_n, wr_n, ifc_n, ren_n, ok;
   logic [2:0] rsel;
   logic [4:0] addr_sw;
   logic [7:0] wdata, rdv, dio_n_oe, m_dio_n, cpu_rdata;
   logic [15:0] lfsr_v;
   logic dav_n_oe, nrfd_n_oe, ndac_n_oe, eoi_n_oe, srq_n_oe, xcvr_transmit;
   logic m_atn_n, m_eoi_n, m_dav_n, remote_mode, listener_active, talker_active;
   logic [7:0] sent_q[$];
   int error_cnt, checked;
   gpib_port uut (.clk(clk), .sys_rst(sys_rst), .dio_n_in(m_dio_n & dio_n_oe), .dio_n_oe(dio_n_oe),
      .dav_n_in(m_dav_n & dav_n_oe), .dav_n_oe(dav_n_oe), .nrfd_n_in(nrfd_n_oe), .nrfd_n_oe(nrfd_n_oe),
      .ndac_n_in(ndac_n_oe), .ndac_n_oe(ndac_n_oe), .atn_n_in(m_atn_n), .ifc_n_in(ifc_n), .ren_n_in(ren_n),
      .eoi_n_in(m_eoi_n & eoi_n_oe), .eoi_n_oe(eoi_n_oe), .srq_n_oe(srq_n_oe), .xcvr_transmit(xcvr_transmit),
      .addr_switch(addr_sw), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .register_select(rsel),
      .cpu_wdata(wdata), .cpu_rdata(cpu_rdata), .remote_mode(remote_mode),
      .listener_active(listener_active), .talker_active(talker_active));
   gpib_ctrl_model ctrl (.clk(clk), .nrfd_n(nrfd_n_oe), .ndac_n(ndac_n_oe), .atn_n(m_atn_n),
      .eoi_n(m_eoi_n), .dav_n(m_dav_n), .dio_n(m_dio_n));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] cmd_byte(input logic [4:0] a, input logic listen);
      logic [7:0] b;
      begin
         b = {3'h0, a};
         b[listen ? GPIB_LISTEN_BIT : GPIB_TALK_BIT] = 1'h1;
         return b;
      end
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      begin
         checked++;
         if (got !== exp)
         begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task automatic settle();
      begin
         repeat (10) @(posedge clk);
         #1;
      end
   endtask
   task automatic send(input logic atn, input logic [7:0] b, input int gap);
      begin
         ctrl.send_byte(atn, b, gap, ok);
         chk("handshake", 8'h01, {7'h0, ok});
         settle();
      end
   endtask
   // strobes held long enough to pass the input synchronisers
   task automatic cpu(input logic wr, input logic [2:0] rs, input logic [7:0] wd);
      begin
         @(posedge clk);
         #1;
         cs_n = 1'h0;
         rd_n = wr;
         wr_n = ~wr;
         rsel = rs;
         wdata = wd;
         repeat (6) @(posedge clk);
         #1;
         rdv = cpu_rdata;
         cs_n = 1'h1;
         rd_n = 1'h1;
         wr_n = 1'h1;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic print_verdict();
      begin
         if (error_cnt == 0 && checked > 0)
         begin
            $display("ALL CHECKS OK");
         end
         else
         begin
            $display("CHECKS NOT OK");
         end
         $finish;
      end
   endtask
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
   initial
   begin
      sys_rst = 1'h1;
      cs_n = 1'h1;
      rd_n = 1'h1;
      wr_n = 1'h1;
      rsel = 3'h0;
      wdata = 8'h00;
      ifc_n = 1'h1;
      ren_n = 1'h1;
      error_cnt = 0;
      checked = 0;
      lfsr_v = 16'h4b3b;
      addr_sw = lfsr_v[4:0];
      repeat (20) @(posedge clk);
      #1;
      chk("nrfd_rst", 8'h00, {7'h0, nrfd_n_oe});
      chk("ndac_rst", 8'h00, {7'h0, ndac_n_oe});
      chk("dio_rst", 8'hff, dio_n_oe);
      chk("dav_rst", 8'h01, {7'h0, dav_n_oe});
      sys_rst = 1'h0;
      settle();
      chk("nrfd_ready", 8'h01, {7'h0, nrfd_n_oe});
      chk("ndac_ready", 8'h00, {7'h0, ndac_n_oe});
      chk("srq_idle", 8'h01, {7'h0, srq_n_oe});
      send(1'h1, cmd_byte(addr_sw ^ {lfsr_v[8:5], 1'h1}, 1'h1), 0);
      chk("listen_miss", 8'h00, {7'h0, listener_active});
      send(1'h1, cmd_byte(addr_sw, 1'h1), 0);
      chk("listen_hit", 8'h01, {7'h0, listener_active});
      chk("talk_off", 8'h00, {7'h0, talker_active});
      cpu(1'h0, GPIB_RS_STATUS, 8'h00);
      chk("status_role", 8'h02, rdv & 8'h03);
      for (int r = 0; r < 2; r++)
      begin
         for (int i = 0; i < GPIB_FIFO_DEPTH; i++)
         begin
            lfsr_v = lfsr_next(lfsr_v);
            sent_q.push_back(lfsr_v[7:0]);
            send(1'h0, lfsr_v[7:0], i * 3);
         end
         chk("nrfd_full", 8'h00, {7'h0, nrfd_n_oe});
         cpu(1'h0, GPIB_RS_STATUS, 8'h00);
         chk("rx_valid", 8'h08, rdv & 8'h08);
         for (int i = 0; i < GPIB_FIFO_DEPTH; i++)
         begin
            cpu(1'h0, GPIB_RS_DATA, 8'h00);
            chk("rx_data", sent_q.pop_front(), rdv);
            chk("nrfd_room", 8'h01, {7'h0, nrfd_n_oe});
         end
      end
      cpu(1'h0, GPIB_RS_ADDR, 8'h00);
      chk("addr_reg", {3'h0, addr_sw}, rdv);
      cpu(1'h0, 3'h7, 8'h00);
      chk("last_cmd", cmd_byte(addr_sw, 1'h1), rdv);
      cpu(1'h1, GPIB_RS_CTRL, 8'h01);
      chk("srq_on", 8'h00, {7'h0, srq_n_oe});
      cpu(1'h1, GPIB_RS_CTRL, 8'h00);
      chk("srq_off", 8'h01, {7'h0, srq_n_oe});
      ren_n = 1'h0;
      settle();
      chk("remote_on", 8'h01, {7'h0, remote_mode});
      ren_n = 1'h1;
      settle();
      chk("remote_off", 8'h00, {7'h0, remote_mode});
      ctrl.set_mgmt(1'h1, 1'h1);
      cpu(1'h0, GPIB_RS_STATUS, 8'h00);
      chk("poll", 8'h81, rdv & 8'h81);
      ctrl.set_mgmt(1'h0, 1'h0);
      ifc_n = 1'h0;
      settle();
      ifc_n = 1'h1;
      settle();
      chk("ifc_listen", 8'h00, {7'h0, listener_active});
      send(1'h1, cmd_byte(addr_sw, 1'h0), 5);
      chk("talk_on", 8'h01, {7'h0, talker_active});
      chk("xcvr_tx", 8'h01, {7'h0, xcvr_transmit});
      lfsr_v = lfsr_next(lfsr_v);
      cpu(1'h1, GPIB_RS_DATA, lfsr_v[7:0]);
      chk("talk_dio", ~lfsr_v[7:0], dio_n_oe);
      cpu(1'h1, GPIB_RS_CTRL, 8'h02);
      chk("eoi_on", 8'h00, {7'h0, eoi_n_oe});
      ifc_n = 1'h0;
      settle();
      ifc_n = 1'h1;
      settle();
      chk("ifc_talk", 8'h00, {7'h0, talker_active});
      chk("xcvr_rx", 8'h00, {7'h0, xcvr_transmit});
      chk("dio_idle", 8'hff, dio_n_oe);
      chk("eoi_off", 8'h01, {7'h0, eoi_n_oe});
      // second reset in mid-run: both handshake lines must fall again
      sys_rst = 1'h1;
      @(posedge clk);
      #1;
      chk("nrfd_rst2", 8'h00, {7'h0, nrfd_n_oe});
      chk("ndac_rst2", 8'h00, {7'h0, ndac_n_oe});
      sys_rst = 1'h0;
      settle();
      chk("nrfd_again", 8'h01, {7'h0, nrfd_n_oe});
      print_verdict();
   end
endmodule
